// ==== design/tag_filter_defs.svh ====
`ifndef TAG_FILTER_DEFS_SVH
`define TAG_FILTER_DEFS_SVH

// Clock and time base
`define CLK_PERIOD_NS 8
`define ONE_SEC_NS 1000000000
`define UNIQUE_LIMIT_S 120
`define RETX_DEFAULT_S 8'h01

// Widths and depths
`define ID_W 64
`define FIFO_DEPTH 8
`define AGE_W 9

// ASCII bounds for hex digits
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CH_UA 8'h41
`define CH_UF 8'h46
`define CH_LA 8'h61
`define CH_LF 8'h66
`define HEX_TEN 4'hA

// Command lengths in characters
`define LEN_TWO 3'h2
`define LEN_THREE 3'h3
`define LEN_FOUR 3'h4

// Command codes, digits packed one per nibble
`define CMD_ALL 8'h40
`define CMD_SEP1 16'h4100
`define CMD_SEP2 16'h4101
`define CMD_RETX 8'h46
`define CMD_EMUL_OFF 12'h450
`define CMD_EMUL_ON 12'h451
`define CMD_GRP1_OFF 12'h452
`define CMD_GRP1_ON 12'h453
`define CMD_SORT_OFF 12'h454
`define CMD_SORT_ON 12'h455
`define CMD_INIT_ON 12'h456
`define CMD_INIT_OFF 12'h457
`define CMD_GRP2_OFF 12'h458
`define CMD_GRP2_ON 12'h459
`define CMD_MODE_DUAL1 12'h470
`define CMD_MODE_LEGACY 12'h471
`define CMD_MODE_ID 12'h472
`define CMD_MODE_EXT 12'h473
`define CMD_MODE_DUAL2 12'h474
`define CMD_MODE_NOEAC 12'h477

`endif

// ==== design/tag_filter_pkg.sv ====
package tag_filter_pkg;

    // Tag read modes
    typedef enum logic [2:0] {
        MODE_DUAL1,
        MODE_LEGACY,
        MODE_ID,
        MODE_EXT,
        MODE_DUAL2,
        MODE_ID_NOEAC
    } read_mode_t;

    // Tag pipeline states
    typedef enum logic {
        ST_IDLE,
        ST_HOLD
    } pipe_state_t;

endpackage : tag_filter_pkg

// ==== design/id_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tag_filter_defs.svh"

module id_fifo #(
    parameter int W = `ID_W,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [CW-1:0] count;
        logic full;
        logic nonempty;
    } fifo_st_t;

    fifo_st_t q;
    fifo_st_t d;
    logic push;
    logic pop;
    logic [CW-1:0] wr_idx;

    // Shift-down storage keeps the head in slot 0, so the output is a flop
    always_comb begin
        d = q;
        push = in_valid_in && !q.full;
        pop = out_ready_in && q.nonempty;
        wr_idx = pop ? q.count - 1'b1 : q.count;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                d.mem[i] = q.mem[i+1];
            end
        end
        if (push) begin
            d.mem[wr_idx] = in_data_in;
        end
        if (push && !pop) begin
            d.count = q.count + 1'b1;
        end else if (pop && !push) begin
            d.count = q.count - 1'b1;
        end
        d.full = (d.count == CW'(DEPTH));
        d.nonempty = (d.count != '0);
    end

    // State register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_ready_out = !q.full;
    assign out_valid_out = q.nonempty;
    assign out_data_out = q.mem[0];

    // Count never passes the depth and flags track it
    a_fifo_flags: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (q.count <= CW'(DEPTH)) && (q.full == (q.count == CW'(DEPTH))) && (q.nonempty == (q.count != '0)))
        else $error("fifo flags disagree with count");

endmodule : id_fifo
`default_nettype wire

// ==== design/tag_id_filter.sv ====
//
// Overview of operation
// - Transmit-all bypasses uniqueness until criterion reselected
// - 4100 separation one default, 4101 two
// - Two-entry store, latest and distinct previous
// - Separation one: send if differs from latest
// - Separation two: send if differs from both
// - Store updated by every acquired ID
// - Repeat ID accepted after two minutes
// - 450 emulation off default, 451 on
// - Emulation sends formatted tags on emulation output
// - Unformatted tags dropped in emulation; relay always
// - 452 group one off default, 453 on
// - 458 group two off default, 459 on
// - 454 sorting off default, 455 on
// - 456 default: initialize tags during sorting
// - 457: no initialize, identified tags skipped
// - 46NN retransmit seconds 01 to FF, default 01
// - Legacy mode doubles retransmit period
// - Hex interval digits accepted in either case
// - 470 dual, 471 legacy, 473 extended default
// - 472 ID only, 474 ID plus legacy
// - 477 reads ID without application code check
//
`timescale 1ns/100ps
`default_nettype none
`include "tag_filter_defs.svh"

module tag_id_filter #(
    parameter int ID_W = `ID_W,
    parameter int FIFO_DEPTH = `FIFO_DEPTH,
    parameter int SEC_CYCLES = `ONE_SEC_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Parsed command from serial front end
    input wire logic cmd_valid_in,
    input wire logic [31:0] cmd_text_in,
    input wire logic [2:0] cmd_len_in,
    // Command reply
    output logic reply_valid_out,
    output logic reply_ok_out,
    // Acquired tag from the decoder
    input wire logic tag_valid_in,
    output logic tag_ready_out,
    input wire logic [ID_W-1:0] tag_id_in,
    input wire logic tag_enhanced_in,
    input wire logic tag_emul_fmt_in,
    input wire logic tag_group1_in,
    input wire logic tag_group2_in,
    input wire logic tag_app_code_ok_in,
    // IDs toward the host serial port
    output logic host_valid_out,
    input wire logic host_ready_in,
    output logic [ID_W-1:0] host_id_out,
    // IDs toward the emulation data pair
    output logic wieg_valid_out,
    input wire logic wieg_ready_in,
    output logic [ID_W-1:0] wieg_id_out,
    // Lock relay pulse
    output logic relay_pulse_out,
    // Configuration seen by the radio side
    output logic unique_off_out,
    output logic unique_sep2_out,
    output logic emul_enable_out,
    output logic group1_enable_out,
    output logic group2_enable_out,
    output logic sort_enable_out,
    output logic sort_init_out,
    output var tag_filter_pkg::read_mode_t read_mode_out,
    output logic [7:0] retx_interval_out
);
    import tag_filter_pkg::*;

    localparam int AW = `AGE_W;
    localparam int SEC_W = $clog2(SEC_CYCLES);

    typedef struct packed {
        pipe_state_t st;
        logic tag_rdy;
        logic [ID_W-1:0] p_id;
        logic p_emfmt;
        logic [ID_W-1:0] e1;
        logic [ID_W-1:0] e2;
        logic v1;
        logic v2;
        logic [AW-1:0] a1;
        logic [AW-1:0] a2;
        logic [SEC_W-1:0] tick_cnt;
        logic [AW-1:0] retx_age;
        logic [ID_W-1:0] last_wieg;
        logic last_wieg_v;
        logic wv;
        logic [ID_W-1:0] wid;
        logic relay;
        logic rv;
        logic rok;
        logic all_mode;
        logic sep2;
        logic emul;
        logic grp1;
        logic grp2;
        logic sort_en;
        logic sort_init;
        read_mode_t mode;
        logic [7:0] retx;
    } state_t;

    state_t q;
    state_t d;

    // Hex digit decode, returns valid flag over value
    function automatic logic [4:0] hex_digit(input logic [7:0] c);
        logic [4:0] r;
        r = '0;
        if (c >= `CH_ZERO && c <= `CH_NINE) begin
            r = {1'b1, 4'(c - `CH_ZERO)};
        end else if (c >= `CH_UA && c <= `CH_UF) begin
            r = {1'b1, 4'(c - `CH_UA) + `HEX_TEN};
        end else if (c >= `CH_LA && c <= `CH_LF) begin
            r = {1'b1, 4'(c - `CH_LA) + `HEX_TEN};
        end
        return r;
    endfunction : hex_digit

    // Seconds counters saturate rather than wrap, so old IDs stay old
    function automatic logic [AW-1:0] sat_inc(input logic [AW-1:0] v);
        return (v == '1) ? v : v + 1'b1;
    endfunction : sat_inc

    // Which tags the selected read mode lets through
    function automatic logic mode_ok(input read_mode_t m, input logic enh, input logic eac);
        logic r;
        r = 1'b0;
        if (enh) begin
            r = (m != MODE_LEGACY) && ((m == MODE_ID_NOEAC) || eac);
        end else begin
            r = (m == MODE_DUAL1) || (m == MODE_LEGACY) || (m == MODE_DUAL2);
        end
        return r;
    endfunction : mode_ok

    logic tick;
    logic cap;
    logic acq;
    logic proc;
    logic m1;
    logic m2;
    logic uniq;
    logic retx_due;
    logic push;
    logic wsend;
    logic fifo_ready;
    logic [AW-1:0] period;
    logic [4:0] h0;
    logic [4:0] h1;
    logic [4:0] h2;
    logic [4:0] h3;
    logic [11:0] code12;
    logic [15:0] code16;
    logic ok3;
    logic ok4;

    // Next-state logic for tag path and command decode
    always_comb begin
        d = q;
        d.relay = 1'b0;
        d.rv = 1'b0;

        // One-second time base for ages and retransmit
        tick = (q.tick_cnt == SEC_W'(SEC_CYCLES - 1));
        d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
        if (tick) begin
            d.a1 = sat_inc(q.a1);
            d.a2 = sat_inc(q.a2);
            d.retx_age = sat_inc(q.retx_age);
        end

        // Emulation word leaves on handshake
        if (q.wv && wieg_ready_in) begin
            d.wv = 1'b0;
        end

        // Capture stage applies mode and group filters
        cap = tag_valid_in && q.tag_rdy && (q.st == ST_IDLE);
        acq = cap && mode_ok(q.mode, tag_enhanced_in, tag_app_code_ok_in)
            && (!q.grp1 || tag_group1_in)
            && (!q.grp2 || tag_group2_in);
        if (acq) begin
            d.st = ST_HOLD;
            d.p_id = tag_id_in;
            d.p_emfmt = tag_emul_fmt_in;
            d.relay = 1'b1;
        end

        // Uniqueness against the two-entry store; stale entries do not block
        m1 = q.v1 && (q.e1 == q.p_id) && (q.a1 <= AW'(`UNIQUE_LIMIT_S));
        m2 = q.v2 && (q.e2 == q.p_id) && (q.a2 <= AW'(`UNIQUE_LIMIT_S));
        uniq = q.all_mode || (q.sep2 ? !(m1 || m2) : !m1);

        // Retransmit period doubles in legacy read mode
        period = (q.mode == MODE_LEGACY) ? {q.retx, 1'b0} : {1'b0, q.retx};
        retx_due = q.last_wieg_v && (q.last_wieg == q.p_id) && (q.retx_age >= period);

        // Process only when both outputs can take the word
        proc = (q.st == ST_HOLD) && fifo_ready && !q.wv;
        push = proc && uniq && !q.emul;
        wsend = proc && q.emul && q.p_emfmt && (uniq || retx_due);
        if (proc) begin
            d.st = ST_IDLE;
            if (q.v1 && (q.e1 == q.p_id)) begin
                d.a1 = '0;
            end else begin
                d.e2 = q.e1;
                d.v2 = q.v1;
                d.a2 = d.a1;
                d.e1 = q.p_id;
                d.v1 = 1'b1;
                d.a1 = '0;
            end
        end
        if (wsend) begin
            d.wv = 1'b1;
            d.wid = q.p_id;
            d.last_wieg = q.p_id;
            d.last_wieg_v = 1'b1;
            d.retx_age = '0;
        end
        // Ready is registered from the next state, so it drops on the same edge as a capture
        d.tag_rdy = (d.st == ST_IDLE);

        // Command text, first character in the top byte
        h0 = hex_digit(cmd_text_in[31:24]);
        h1 = hex_digit(cmd_text_in[23:16]);
        h2 = hex_digit(cmd_text_in[15:8]);
        h3 = hex_digit(cmd_text_in[7:0]);
        code12 = {h0[3:0], h1[3:0], h2[3:0]};
        code16 = {code12, h3[3:0]};
        ok3 = h0[4] && h1[4] && h2[4];
        ok4 = ok3 && h3[4];
        if (cmd_valid_in) begin
            d.rv = 1'b1;
            d.rok = 1'b1;
            if (cmd_len_in == `LEN_TWO && h0[4] && h1[4] && code12[11:4] == `CMD_ALL) begin
                d.all_mode = 1'b1;
            end else if (cmd_len_in == `LEN_FOUR && ok4 && code16 == `CMD_SEP1) begin
                d.all_mode = 1'b0;
                d.sep2 = 1'b0;
            end else if (cmd_len_in == `LEN_FOUR && ok4 && code16 == `CMD_SEP2) begin
                d.all_mode = 1'b0;
                d.sep2 = 1'b1;
            end else if (cmd_len_in == `LEN_FOUR && ok4 && code16[15:8] == `CMD_RETX
                         && code16[7:0] != 8'h00) begin
                d.retx = code16[7:0];
            end else if (cmd_len_in == `LEN_THREE && ok3) begin
                case (code12)
                    `CMD_EMUL_OFF: d.emul = 1'b0;
                    `CMD_EMUL_ON: d.emul = 1'b1;
                    `CMD_GRP1_OFF: d.grp1 = 1'b0;
                    `CMD_GRP1_ON: d.grp1 = 1'b1;
                    `CMD_SORT_OFF: d.sort_en = 1'b0;
                    `CMD_SORT_ON: d.sort_en = 1'b1;
                    `CMD_INIT_ON: d.sort_init = 1'b1;
                    `CMD_INIT_OFF: d.sort_init = 1'b0;
                    `CMD_GRP2_OFF: d.grp2 = 1'b0;
                    `CMD_GRP2_ON: d.grp2 = 1'b1;
                    `CMD_MODE_DUAL1: d.mode = MODE_DUAL1;
                    `CMD_MODE_LEGACY: d.mode = MODE_LEGACY;
                    `CMD_MODE_ID: d.mode = MODE_ID;
                    `CMD_MODE_EXT: d.mode = MODE_EXT;
                    `CMD_MODE_DUAL2: d.mode = MODE_DUAL2;
                    `CMD_MODE_NOEAC: d.mode = MODE_ID_NOEAC;
                    default: d.rok = 1'b0;
                endcase
            end else begin
                d.rok = 1'b0;
            end
        end
    end

    // State register with power-on defaults
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.tag_rdy <= 1'b1;
            q.sort_init <= 1'b1;
            q.mode <= MODE_EXT;
            q.retx <= `RETX_DEFAULT_S;
        end else begin
            q <= d;
        end
    end

    // Host path buffer; a stalled host backs up into the capture stage
    id_fifo #(
        .W(ID_W),
        .DEPTH(FIFO_DEPTH)
    ) u_host_fifo (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .in_valid_in(push),
        .in_ready_out(fifo_ready),
        .in_data_in(q.p_id),
        .out_valid_out(host_valid_out),
        .out_ready_in(host_ready_in),
        .out_data_out(host_id_out)
    );

    // Outputs straight from the state register
    assign tag_ready_out = q.tag_rdy;
    assign reply_valid_out = q.rv;
    assign reply_ok_out = q.rok;
    assign wieg_valid_out = q.wv;
    assign wieg_id_out = q.wid;
    assign relay_pulse_out = q.relay;
    assign unique_off_out = q.all_mode;
    assign unique_sep2_out = q.sep2;
    assign emul_enable_out = q.emul;
    assign group1_enable_out = q.grp1;
    assign group2_enable_out = q.grp2;
    assign sort_enable_out = q.sort_en;
    assign sort_init_out = q.sort_init;
    assign read_mode_out = q.mode;
    assign retx_interval_out = q.retx;

    a_relay_on_acquire: assert property (@(posedge clk_in) disable iff (!resetn_in)
        acq |=> relay_pulse_out ##1 !relay_pulse_out)
        else $error("relay pulse missing after acquired tag");

    a_all_mode_pass: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (proc && q.all_mode && !q.emul) |=> host_valid_out)
        else $error("transmit-all dropped an ID");

    a_sep_one_block: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (proc && !q.all_mode && !q.sep2 && q.v1 && q.e1 == q.p_id && q.a1 <= AW'(`UNIQUE_LIMIT_S)) |-> !push)
        else $error("repeat of latest ID was sent");

    a_sep_two_block: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (proc && !q.all_mode && q.sep2 && q.v2 && q.e2 == q.p_id && q.a2 <= AW'(`UNIQUE_LIMIT_S)) |-> !push)
        else $error("repeat of second ID was sent");

    a_store_update: assert property (@(posedge clk_in) disable iff (!resetn_in)
        proc |=> (q.e1 == $past(q.p_id)) && q.v1 && (q.e1 != q.e2 || !q.v2))
        else $error("store not updated with processed ID");

    a_emul_no_host: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (proc && q.emul) |-> !push ##1 (q.wv == ($past(q.p_emfmt) && ($past(uniq) || $past(retx_due)))))
        else $error("emulation routing wrong");

    a_sep_select: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (cmd_valid_in && cmd_len_in == `LEN_FOUR && cmd_text_in == 32'h34313031)
        |=> unique_sep2_out && !unique_off_out && reply_valid_out && reply_ok_out)
        else $error("separation two not selected");

    a_bad_interval: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (cmd_valid_in && cmd_len_in == `LEN_FOUR && cmd_text_in == 32'h34363030)
        |=> reply_valid_out && !reply_ok_out && $stable(retx_interval_out))
        else $error("zero interval not refused");

    a_case_interval: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (cmd_valid_in && cmd_len_in == `LEN_FOUR && cmd_text_in == 32'h34366641)
        |=> retx_interval_out == 8'hFA && reply_ok_out)
        else $error("lower case interval not taken");

endmodule : tag_id_filter
`default_nettype wire

// ==== verification/tag_sink_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module tag_sink_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Slow mode from the bench
    input wire logic stall_in,
    // Offered word
    input wire logic valid_in,
    input wire logic [63:0] id_in,
    output logic ready_out,
    // Accepted word
    output logic got_out,
    output logic [63:0] got_id_out
);
    // Ready moves only after an edge; a stall holds it low as long as asked
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ready_out <= 1'b0;
        end else begin
            ready_out <= !stall_in;
        end
    end

    // A word is taken on an edge that sees valid and ready together
    assign got_out = valid_in & ready_out;
    assign got_id_out = id_in;
endmodule : tag_sink_model

`default_nettype wire

// ==== verification/tag_id_filter_test.sv ====
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            n_fail++; \
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module tag_id_filter_test;
    import tag_filter_pkg::*;
    // Bench driven inputs, all set at time zero
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cmd_valid_in = 1'b0;
    logic [31:0] cmd_text_in = 32'h0;
    logic [2:0] cmd_len_in = 3'h0;
    logic tag_valid_in = 1'b0;
    logic [63:0] tag_id_in = 64'h0;
    logic [4:0] tag_f = 5'h1F;
    logic host_stall = 1'b0;
    logic wieg_stall = 1'b0;
    // Design outputs and partner links
    logic reply_valid_out, reply_ok_out, tag_ready_out, host_valid_out, host_ready_in;
    logic wieg_valid_out, wieg_ready_in, relay_pulse_out, h_got, w_got;
    logic unique_off_out, unique_sep2_out, emul_enable_out, group1_enable_out;
    logic group2_enable_out, sort_enable_out, sort_init_out;
    logic [63:0] host_id_out, wieg_id_out, h_id, w_id;
    read_mode_t read_mode_out;
    logic [7:0] retx_interval_out;
    logic [63:0] hq[$];
    logic [63:0] wq[$];
    int n_fail = 0;
    int total_checks = 0;
    int n_relay = 0;
    int cycles = 0;
    int i;

    // 125 MHz clock
    always #4 clk_in = ~clk_in;

    // Ten cycles per second keeps the two minute window short
    tag_id_filter #(.SEC_CYCLES(10)) dut (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .cmd_valid_in(cmd_valid_in), .cmd_text_in(cmd_text_in), .cmd_len_in(cmd_len_in),
        .reply_valid_out(reply_valid_out), .reply_ok_out(reply_ok_out),
        .tag_valid_in(tag_valid_in), .tag_ready_out(tag_ready_out), .tag_id_in(tag_id_in),
        .tag_enhanced_in(tag_f[4]), .tag_emul_fmt_in(tag_f[3]), .tag_group1_in(tag_f[2]),
        .tag_group2_in(tag_f[1]), .tag_app_code_ok_in(tag_f[0]),
        .host_valid_out(host_valid_out), .host_ready_in(host_ready_in), .host_id_out(host_id_out),
        .wieg_valid_out(wieg_valid_out), .wieg_ready_in(wieg_ready_in), .wieg_id_out(wieg_id_out),
        .relay_pulse_out(relay_pulse_out), .unique_off_out(unique_off_out),
        .unique_sep2_out(unique_sep2_out), .emul_enable_out(emul_enable_out),
        .group1_enable_out(group1_enable_out), .group2_enable_out(group2_enable_out),
        .sort_enable_out(sort_enable_out), .sort_init_out(sort_init_out),
        .read_mode_out(read_mode_out), .retx_interval_out(retx_interval_out)
    );

    // Host serial side and emulation receiver
    tag_sink_model host_side (.clk_in(clk_in), .resetn_in(resetn_in), .stall_in(host_stall),
        .valid_in(host_valid_out), .id_in(host_id_out), .ready_out(host_ready_in),
        .got_out(h_got), .got_id_out(h_id));
    tag_sink_model wieg_side (.clk_in(clk_in), .resetn_in(resetn_in), .stall_in(wieg_stall),
        .valid_in(wieg_valid_out), .id_in(wieg_id_out), .ready_out(wieg_ready_in),
        .got_out(w_got), .got_id_out(w_id));

    // Collect deliveries and relay pulses; cut a hang short
    always @(posedge clk_in) begin
        cycles++;
        if (h_got === 1'b1)
            hq.push_back(h_id);
        if (w_got === 1'b1)
            wq.push_back(w_id);
        if (relay_pulse_out === 1'b1)
            n_relay++;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    task complete_run;
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // Right-justified text is left-aligned here and its length derived
    task cmd(input logic [31:0] t, input logic ok);
        logic [2:0] n;
        n = 3'h4;
        while (t[31:24] == 8'h00) begin
            t = t << 8;
            n = n - 3'h1;
        end
        @(negedge clk_in);
        cmd_valid_in = 1'b1;
        cmd_text_in = t;
        cmd_len_in = n;
        @(negedge clk_in);
        cmd_valid_in = 1'b0;
        `CHK("reply valid", 1'b1, reply_valid_out)
        `CHK("reply ok", ok, reply_ok_out)
    endtask : cmd

    task set_mode(input logic [23:0] t, input read_mode_t m);
        cmd({8'h00, t}, 1'b1);
        `CHK("read mode", m, read_mode_out)
    endtask : set_mode

    // One tag offered; h, w, r are the expected host, emulation and relay counts
    task send_tag(input logic [63:0] id, input logic [4:0] f, input int h, input int w, input int r);
        int r0;
        int k;
        r0 = n_relay;
        @(negedge clk_in);
        tag_valid_in = 1'b1;
        tag_id_in = id;
        tag_f = f;
        for (k = 0; k < 400 && tag_ready_out !== 1'b1; k++)
            @(negedge clk_in);
        @(negedge clk_in);
        tag_valid_in = 1'b0;
        tag_id_in = ~id;
        tag_f = ~f;
        repeat (8) @(negedge clk_in);
        `CHK("relay pulses", r, n_relay - r0)
        `CHK("host words", h, hq.size())
        `CHK("emulation words", w, wq.size())
        if (h == 1 && hq.size() == 1)
            `CHK("host id", id, hq[0])
        if (w == 1 && wq.size() == 1)
            `CHK("emulation id", id, wq[0])
        hq.delete();
        wq.delete();
    endtask : send_tag

    task t_defaults;
        `CHK("transmit all", 1'b0, unique_off_out)
        `CHK("separation two", 1'b0, unique_sep2_out)
        `CHK("emulation", 1'b0, emul_enable_out)
        `CHK("group one", 1'b0, group1_enable_out)
        `CHK("group two", 1'b0, group2_enable_out)
        `CHK("sorting", 1'b0, sort_enable_out)
        `CHK("sort init", 1'b1, sort_init_out)
        `CHK("read mode", MODE_EXT, read_mode_out)
        `CHK("retransmit", 8'h01, retx_interval_out)
    endtask : t_defaults

    task t_commands;
        cmd("455", 1'b1);
        `CHK("sorting", 1'b1, sort_enable_out)
        cmd("457", 1'b1);
        `CHK("sort init", 1'b0, sort_init_out)
        cmd("456", 1'b1);
        cmd("454", 1'b1);
        `CHK("sort pair", 2'h1, {sort_enable_out, sort_init_out})
        cmd("4101", 1'b1);
        `CHK("separation two", 1'b1, unique_sep2_out)
        cmd("4102", 1'b0);
        `CHK("separation kept", 1'b1, unique_sep2_out)
        cmd("46fA", 1'b1);
        `CHK("retransmit", 8'hFA, retx_interval_out)
        cmd("4600", 1'b0);
        cmd("46G1", 1'b0);
        `CHK("retransmit kept", 8'hFA, retx_interval_out)
        cmd("46FF", 1'b1);
        `CHK("retransmit", 8'hFF, retx_interval_out)
        cmd("475", 1'b0);
        cmd("41", 1'b0);
        set_mode("470", MODE_DUAL1);
        set_mode("471", MODE_LEGACY);
        set_mode("472", MODE_ID);
        set_mode("474", MODE_DUAL2);
        set_mode("477", MODE_ID_NOEAC);
        set_mode("473", MODE_EXT);
        cmd("40", 1'b1);
        `CHK("transmit all", 1'b1, unique_off_out)
        cmd("4100", 1'b1);
        `CHK("criterion back", 2'h0, {unique_off_out, unique_sep2_out})
        cmd("4601", 1'b1);
    endtask : t_commands

    task t_filters;
        send_tag(64'hA1, 5'h1F, 1, 0, 1);
        send_tag(64'hA1, 5'h1F, 0, 0, 1);
        send_tag(64'hB2, 5'h1F, 1, 0, 1);
        send_tag(64'hA1, 5'h1F, 1, 0, 1);
        cmd("4101", 1'b1);
        send_tag(64'hC3, 5'h1F, 1, 0, 1);
        send_tag(64'hD4, 5'h1F, 1, 0, 1);
        send_tag(64'hC3, 5'h1F, 0, 0, 1);
        send_tag(64'hE5, 5'h1F, 1, 0, 1);
        send_tag(64'hD4, 5'h1F, 1, 0, 1);
        cmd("40", 1'b1);
        send_tag(64'hE5, 5'h1F, 1, 0, 1);
        send_tag(64'hE5, 5'h1F, 1, 0, 1);
        cmd("4100", 1'b1);
        send_tag(64'h77, 5'h1F, 1, 0, 1);
        send_tag(64'h77, 5'h1F, 0, 0, 1);
        repeat (1300) @(negedge clk_in);
        send_tag(64'h77, 5'h1F, 1, 0, 1);
        cmd("453", 1'b1);
        send_tag(64'h81, 5'h1B, 0, 0, 0);
        send_tag(64'h82, 5'h1F, 1, 0, 1);
        cmd("452", 1'b1);
        cmd("459", 1'b1);
        send_tag(64'h83, 5'h1D, 0, 0, 0);
        send_tag(64'h84, 5'h1F, 1, 0, 1);
        cmd("458", 1'b1);
        send_tag(64'h85, 5'h0F, 0, 0, 0);
        set_mode("471", MODE_LEGACY);
        send_tag(64'h86, 5'h1F, 0, 0, 0);
        send_tag(64'h86, 5'h0F, 1, 0, 1);
        set_mode("472", MODE_ID);
        send_tag(64'h87, 5'h0F, 0, 0, 0);
        set_mode("474", MODE_DUAL2);
        send_tag(64'h87, 5'h0F, 1, 0, 1);
        set_mode("477", MODE_ID_NOEAC);
        send_tag(64'h88, 5'h1E, 1, 0, 1);
        set_mode("473", MODE_EXT);
    endtask : t_filters

    task t_emulation;
        cmd("451", 1'b1);
        `CHK("emulation", 1'b1, emul_enable_out)
        send_tag(64'h91, 5'h17, 0, 0, 1);
        cmd("4602", 1'b1);
        send_tag(64'h92, 5'h1F, 0, 1, 1);
        send_tag(64'h92, 5'h1F, 0, 0, 1);
        repeat (30) @(negedge clk_in);
        send_tag(64'h92, 5'h1F, 0, 1, 1);
        set_mode("471", MODE_LEGACY);
        send_tag(64'h93, 5'h0F, 0, 1, 1);
        repeat (15) @(negedge clk_in);
        send_tag(64'h93, 5'h0F, 0, 0, 1);
        repeat (50) @(negedge clk_in);
        send_tag(64'h93, 5'h0F, 0, 1, 1);
        set_mode("473", MODE_EXT);
        // Receiver stalls: the word must wait unchanged
        wieg_stall = 1'b1;
        send_tag(64'h94, 5'h1F, 0, 0, 1);
        `CHK("emulation held", 1'b1, wieg_valid_out)
        `CHK("emulation held id", 64'h94, wieg_id_out)
        wieg_stall = 1'b0;
        repeat (4) @(negedge clk_in);
        `CHK("emulation after stall", 1, wq.size())
        wq.delete();
        cmd("450", 1'b1);
        `CHK("emulation", 1'b0, emul_enable_out)
    endtask : t_emulation

    // Host stalls until the eight word buffer refuses, then drains in order
    task t_buffer;
        host_stall = 1'b1;
        for (i = 0; i < 9; i++)
            send_tag(64'hF0 + 64'(i), 5'h1F, 0, 0, 1);
        `CHK("tag ready while full", 1'b0, tag_ready_out)
        `CHK("host valid while full", 1'b1, host_valid_out)
        host_stall = 1'b0;
        repeat (30) @(negedge clk_in);
        `CHK("drained words", 9, hq.size())
        for (i = 0; i < 9 && i < hq.size(); i++)
            `CHK("drained id", 64'hF0 + 64'(i), hq[i])
        hq.delete();
    endtask : t_buffer

    // Main sequence
    initial begin
        repeat (12) @(negedge clk_in);
        resetn_in = 1'b1;
        t_defaults();
        t_commands();
        t_filters();
        t_emulation();
        t_buffer();
        complete_run();
    end
endmodule : tag_id_filter_test

`default_nettype wire
